//--- verilog/pll_opt_pkg.sv
// Constants and types shared by the dual PLL option control block
package pll_opt_pkg;
  localparam int WORD_W = 19;
  localparam int OPT_W = 17;
  // Select pair sits at the top of the latched word: B at bit 18, A at bit 17
  localparam int SEL_LSB = 17;
  localparam logic [1:0] SEL_OPTION = 2'h1;
  localparam int DRV1_LSB = 0;
  localparam int DRV2_LSB = 3;
  localparam int DRV_W = 3;
  localparam int POL_BIT = 6;
  localparam int PRE1_BIT = 7;
  localparam int PRE2_BIT = 8;
  localparam int AUTO_BIT = 9;
  localparam int LW_LO_BIT = 10;
  localparam int LW_HI_BIT = 11;
  localparam int FL_BIT = 12;
  localparam int RC_HI_BIT = 13;
  localparam int RC_LO_BIT = 14;
  localparam int SR_HI_BIT = 15;
  localparam int SR_LO_BIT = 16;
  localparam logic [OPT_W-1:0] OPT_RST = 17'h00000;
  localparam logic [WORD_W-1:0] WORD_RST = 19'h00000;
  localparam logic [2:0] DRV_VOLTAGE = 3'h7;
  localparam logic [3:0] REV_ONE = 4'h1;
  // APB register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WORD = 8'h08;
  localparam int ST_LOADED = 0;
  localparam int ST_FL_LSB = 1;
  localparam int ST_LOCK_LSB = 3;
  localparam int ST_TM_LSB = 5;
  localparam int ST_LOKI = 7;
  // Pin sampling order
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_STRB = 2;
  localparam int PIN_TEN = 3;
  localparam int PIN_RF1 = 4;
  localparam int PIN_RF2 = 5;
  localparam int PIN_N = 6;
  // Idle pin levels: the serial clock rests high, so no false edge after reset
  localparam logic [PIN_N-1:0] PIN_IDLE = 6'h01;
  // Test mode counts
  localparam logic [4:0] TM3_PULSES = 5'h10;
  localparam logic [6:0] MON_LAST = 7'h40;
  localparam logic [6:0] MON_HIGH = 7'h21;
  typedef enum logic [1:0] {TM_NONE, TM_MON1, TM_MON2, TM_LEAK} test_mode_t;
  typedef enum logic [1:0] {FL_IDLE, FL_SWITCH, FL_DONE} fl_state_t;
endpackage

//--- verilog/pump_chan_if.sv
// Per-channel settings and pump status between option decode and pump logic
`timescale 1ns/1ps
interface pump_chan_if;
  logic [2:0] drive_code;
  logic polarity;
  logic auto_vi;
  logic fl_en;
  logic [3:0] rev_limit;
  logic restart;
  logic leak_test;
  logic sw_open;
  logic lead;
  logic lag;
  logic locked;
  logic pump_o;
  logic pump_oe;
  logic gate_o;
  logic gate_oe;
  logic switch_on;
  logic voltage_mode;
  logic fl_busy;
  modport ctrl (output drive_code, polarity, auto_vi, fl_en, rev_limit, restart,
    leak_test, sw_open, lead, lag, locked, input pump_o, pump_oe, gate_o, gate_oe,
    switch_on, voltage_mode, fl_busy);
  modport chan (input drive_code, polarity, auto_vi, fl_en, rev_limit, restart,
    leak_test, sw_open, lead, lag, locked, output pump_o, pump_oe, gate_o, gate_oe,
    switch_on, voltage_mode, fl_busy);
endinterface

//--- verilog/pump_channel.sv
// One loop's pump routing, fast-lock sequencer and voltage/current select
`timescale 1ns/1ps
module pump_channel
(
  input wire logic clk,
  input wire logic rst_n,
  pump_chan_if.chan bus
);
  pll_opt_pkg::fl_state_t st_ff;
  logic [3:0] rev_cnt_ff;
  logic sign_ff;
  logic seen_ff;
  logic err;
  logic flip;
  logic on_gate;

  assign err = bus.lead ^ bus.lag;
  assign flip = err & seen_ff & (bus.lead != sign_ff);
  assign on_gate = (st_ff == pll_opt_pkg::FL_SWITCH);

  // Every applied option word restarts the sequence
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= pll_opt_pkg::FL_IDLE;
      rev_cnt_ff <= 4'h0;
    end
    else if (bus.restart)
    begin
      st_ff <= bus.fl_en ? pll_opt_pkg::FL_SWITCH : pll_opt_pkg::FL_IDLE;
      rev_cnt_ff <= 4'h0;
    end
    else
    begin
      case (st_ff)
        pll_opt_pkg::FL_SWITCH:
        begin
          if (flip)
          begin
            rev_cnt_ff <= rev_cnt_ff + 4'h1;
            if (rev_cnt_ff + 4'h1 >= bus.rev_limit)
            begin
              st_ff <= pll_opt_pkg::FL_DONE;
            end
          end
        end
        default: st_ff <= st_ff;
      endcase
    end
  end

  // Last error sign; the first error after a restart is not a reversal
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sign_ff <= 1'b0;
      seen_ff <= 1'b0;
    end
    else if (bus.restart)
    begin
      seen_ff <= 1'b0;
    end
    else if (err)
    begin
      seen_ff <= 1'b1;
      sign_ff <= bus.lead;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus.pump_o <= 1'b0;
      bus.pump_oe <= 1'b0;
      bus.gate_o <= 1'b0;
      bus.gate_oe <= 1'b0;
      bus.switch_on <= 1'b0;
      bus.voltage_mode <= 1'b0;
      bus.fl_busy <= 1'b0;
    end
    else
    begin
      bus.pump_o <= bus.polarity ? bus.lead : bus.lag;
      bus.gate_o <= bus.polarity ? bus.lead : bus.lag;
      bus.pump_oe <= err & ~bus.leak_test & ~on_gate;
      bus.gate_oe <= err & ~bus.leak_test & on_gate;
      bus.switch_on <= bus.leak_test ? ~bus.sw_open : on_gate;
      bus.voltage_mode <= (bus.drive_code == pll_opt_pkg::DRV_VOLTAGE) |
        (bus.auto_vi & ~bus.locked);
      bus.fl_busy <= on_gate;
    end
  end

  chk_rev_bound:
  assert property (@(posedge clk) disable iff (!rst_n) on_gate |-> rev_cnt_ff < bus.rev_limit)
    else $error("Reversal count passed its limit while on gate pin");
endmodule

//--- verilog/dual_pll_option_control.sv
// Option word decode, serial load, test modes and lock output of a dual PLL
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module dual_pll_option_control
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pll_opt_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic test_enable,
  input wire logic rf_input_ch1,
  input wire logic rf_input_ch2,
  input wire logic [1:0] phase_lead,
  input wire logic [1:0] phase_lag,
  input wire logic [1:0] loop_locked,
  output logic [1:0] pump_out,
  output logic [1:0] pump_out_oe,
  output logic [1:0] filter_gate_pin,
  output logic [1:0] filter_gate_pin_oe,
  output logic [1:0] fast_lock_switch,
  output logic [1:0] voltage_mode,
  output logic [2:0] drive_code1,
  output logic [2:0] drive_code2,
  output logic prescaler1_on,
  output logic prescaler2_on,
  output logic [1:0] lock_window_sel,
  output logic [1:0] switch_res_sel,
  output logic lock_indicator_o,
  output logic lock_indicator_oe,
  output logic monitor_out
);
  localparam int PN = pll_opt_pkg::PIN_N;
  localparam int WW = pll_opt_pkg::WORD_W;
  localparam int OW = pll_opt_pkg::OPT_W;

  logic [PN-1:0] pin_raw;
  logic [PN-1:0] s1_ff;
  logic [PN-1:0] s2_ff;
  logic [PN-1:0] s3_ff;
  logic [PN-1:0] pin_ff;
  logic [PN-1:0] prev_ff;
  logic [PN-1:0] rise;
  logic [PN-1:0] fall;
  pll_opt_pkg::test_mode_t tm_ff;
  pll_opt_pkg::test_mode_t nxt_tm;
  logic [WW-1:0] shift_ff;
  logic [WW-1:0] word_ff;
  logic [OW-1:0] opt_ff;
  logic loaded_ff;
  logic restart_ff;
  logic latch_evt;
  logic opt_ser;
  logic sw_apply;
  logic leak;
  logic [4:0] tm3_cnt_ff;
  logic tm3_open;
  logic lock_oe_ff;
  logic [1:0] enabled;
  logic all_locked;
  logic [6:0] mon_cnt_ff;
  logic mon_ff;
  logic mon_mode;
  logic mon_edge;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_mux;
  logic [7:0] status;
  logic [1:0] fl_busy;
  logic setup;
  logic mapped;

  // Pins sampled through three flops; a change counts once stages 2 and 3 agree
  assign pin_raw = {rf_input_ch2, rf_input_ch1, test_enable, load_strobe, serial_data,
    serial_clk};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= pll_opt_pkg::PIN_IDLE;
      s2_ff <= pll_opt_pkg::PIN_IDLE;
      s3_ff <= pll_opt_pkg::PIN_IDLE;
      pin_ff <= pll_opt_pkg::PIN_IDLE;
      prev_ff <= pll_opt_pkg::PIN_IDLE;
    end
    else
    begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));
      prev_ff <= pin_ff;
    end
  end

  assign rise = pin_ff & ~prev_ff;
  assign fall = ~pin_ff & prev_ff;

  // Test mode from strobe and data levels while the test pin is raised
  always_comb
  begin
    nxt_tm = pll_opt_pkg::TM_NONE;
    if (pin_ff[pll_opt_pkg::PIN_TEN])
    begin
      case ({pin_ff[pll_opt_pkg::PIN_STRB], pin_ff[pll_opt_pkg::PIN_SDATA]})
        2'h2: nxt_tm = pll_opt_pkg::TM_MON1;
        2'h1: nxt_tm = pll_opt_pkg::TM_MON2;
        2'h3: nxt_tm = pll_opt_pkg::TM_LEAK;
        default: nxt_tm = pll_opt_pkg::TM_NONE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tm_ff <= pll_opt_pkg::TM_NONE;
    end
    else
    begin
      tm_ff <= nxt_tm;
    end
  end

  assign leak = (tm_ff == pll_opt_pkg::TM_LEAK);

  // Strobe and data act as mode selects in test, so loading is held off then
  assign latch_evt = fall[pll_opt_pkg::PIN_STRB] & ~pin_ff[pll_opt_pkg::PIN_TEN];
  assign opt_ser = latch_evt & (shift_ff[WW-1:pll_opt_pkg::SEL_LSB] == pll_opt_pkg::SEL_OPTION);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_ff <= pll_opt_pkg::WORD_RST;
    end
    else if (fall[pll_opt_pkg::PIN_SCLK] & ~pin_ff[pll_opt_pkg::PIN_TEN])
    begin
      shift_ff <= {shift_ff[WW-2:0], pin_ff[pll_opt_pkg::PIN_SDATA]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_ff <= pll_opt_pkg::WORD_RST;
      loaded_ff <= 1'b0;
    end
    else if (latch_evt)
    begin
      word_ff <= shift_ff;
      loaded_ff <= 1'b1;
    end
  end

  // Shifting never disturbs the applied options
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opt_ff <= pll_opt_pkg::OPT_RST;
    end
    else if (opt_ser)
    begin
      opt_ff <= shift_ff[OW-1:0];
    end
    else if (sw_apply)
    begin
      opt_ff <= pwdata[OW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      restart_ff <= 1'b0;
    end
    else
    begin
      restart_ff <= opt_ser | sw_apply;
    end
  end

  // Serial clock pulses in leak test; saturates so the switch stays open
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tm3_cnt_ff <= 5'h00;
    end
    else if (!leak)
    begin
      tm3_cnt_ff <= 5'h00;
    end
    else if (rise[pll_opt_pkg::PIN_SCLK] && tm3_cnt_ff < pll_opt_pkg::TM3_PULSES)
    begin
      tm3_cnt_ff <= tm3_cnt_ff + 5'h01;
    end
  end

  assign tm3_open = (tm3_cnt_ff >= pll_opt_pkg::TM3_PULSES);

  // Open drain: enable high means the pin is pulled low
  assign enabled = {opt_ff[pll_opt_pkg::PRE2_BIT], opt_ff[pll_opt_pkg::PRE1_BIT]};
  assign all_locked = (|enabled) & ((loop_locked | ~enabled) == 2'h3);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_oe_ff <= 1'b0;
    end
    else
    begin
      lock_oe_ff <= leak ? tm3_open : all_locked;
    end
  end

  // Monitor divides the selected input by 65, high for the first 33 periods
  assign mon_mode = (tm_ff == pll_opt_pkg::TM_MON1) | (tm_ff == pll_opt_pkg::TM_MON2);
  assign mon_edge = (tm_ff == pll_opt_pkg::TM_MON1) ? rise[pll_opt_pkg::PIN_RF1] :
    rise[pll_opt_pkg::PIN_RF2];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mon_cnt_ff <= 7'h00;
      mon_ff <= 1'b0;
    end
    else if (!mon_mode)
    begin
      mon_cnt_ff <= 7'h00;
      mon_ff <= 1'b0;
    end
    else
    begin
      if (mon_edge)
      begin
        mon_cnt_ff <= (mon_cnt_ff == pll_opt_pkg::MON_LAST) ? 7'h00 : mon_cnt_ff + 7'h01;
      end
      mon_ff <= (mon_cnt_ff < pll_opt_pkg::MON_HIGH);
    end
  end

  // Channels
  pump_chan_if ch_bus[2] ();

  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    assign ch_bus[i].drive_code = opt_ff[pll_opt_pkg::DRV1_LSB + i * pll_opt_pkg::DRV_W +:
      pll_opt_pkg::DRV_W];
    assign ch_bus[i].polarity = opt_ff[pll_opt_pkg::POL_BIT];
    assign ch_bus[i].auto_vi = opt_ff[pll_opt_pkg::AUTO_BIT];
    assign ch_bus[i].fl_en = opt_ff[pll_opt_pkg::AUTO_BIT] & opt_ff[pll_opt_pkg::FL_BIT];
    assign ch_bus[i].rev_limit = pll_opt_pkg::REV_ONE << {opt_ff[pll_opt_pkg::RC_HI_BIT],
      opt_ff[pll_opt_pkg::RC_LO_BIT]};
    assign ch_bus[i].restart = restart_ff;
    assign ch_bus[i].leak_test = leak;
    assign ch_bus[i].sw_open = tm3_open;
    assign ch_bus[i].lead = phase_lead[i];
    assign ch_bus[i].lag = phase_lag[i];
    assign ch_bus[i].locked = loop_locked[i];
    assign pump_out[i] = ch_bus[i].pump_o;
    assign pump_out_oe[i] = ch_bus[i].pump_oe;
    assign filter_gate_pin[i] = ch_bus[i].gate_o;
    assign filter_gate_pin_oe[i] = ch_bus[i].gate_oe;
    assign fast_lock_switch[i] = ch_bus[i].switch_on;
    assign voltage_mode[i] = ch_bus[i].voltage_mode;
    assign fl_busy[i] = ch_bus[i].fl_busy;
    pump_channel i_pump_channel
    (
      .clk(pclk),
      .rst_n(presetn),
      .bus(ch_bus[i])
    );
  end
  assign drive_code1 = opt_ff[pll_opt_pkg::DRV1_LSB +: pll_opt_pkg::DRV_W];
  assign drive_code2 = opt_ff[pll_opt_pkg::DRV2_LSB +: pll_opt_pkg::DRV_W];
  assign prescaler1_on = opt_ff[pll_opt_pkg::PRE1_BIT];
  assign prescaler2_on = opt_ff[pll_opt_pkg::PRE2_BIT];
  assign lock_window_sel = {opt_ff[pll_opt_pkg::LW_HI_BIT],
    opt_ff[pll_opt_pkg::LW_LO_BIT]};
  assign switch_res_sel = {opt_ff[pll_opt_pkg::SR_HI_BIT], opt_ff[pll_opt_pkg::SR_LO_BIT]};
  assign lock_indicator_o = 1'b0;
  assign lock_indicator_oe = lock_oe_ff;
  assign monitor_out = mon_ff;

  // APB slave: data and pready are prepared in setup, so no wait states
  assign setup = psel & ~penable;
  assign sw_apply = psel & penable & pready_ff & pwrite & (paddr == pll_opt_pkg::OFS_OPTION);
  assign mapped = (paddr == pll_opt_pkg::OFS_OPTION) | (paddr == pll_opt_pkg::OFS_STATUS) |
    (paddr == pll_opt_pkg::OFS_WORD);
  assign status = {lock_oe_ff, tm_ff, loop_locked, fl_busy, loaded_ff};

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      pll_opt_pkg::OFS_OPTION: rd_mux[OW-1:0] = opt_ff;
      pll_opt_pkg::OFS_STATUS: rd_mux[7:0] = status;
      pll_opt_pkg::OFS_WORD: rd_mux[WW-1:0] = word_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup)
      begin
        prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_word_latch:
  assert property (latch_evt |=> word_ff == $past(shift_ff))
    else $error("Latched word differs from the shifted bits");

  chk_option_apply:
  assert property (opt_ser |=> opt_ff == $past(shift_ff[OW-1:0]) ##1 restart_ff == 1'b0)
    else $error("Option word not applied from the latch");

  chk_option_hold:
  assert property (!opt_ser && !sw_apply |=> $stable(opt_ff))
    else $error("Options changed without a latch event");

  chk_pump_polarity:
  assert property (phase_lead[0] && !phase_lag[0] |=> pump_out[0] == $past(opt_ff[6]))
    else $error("Pump level does not follow polarity on lead");

  chk_leak_hiz:
  assert property (leak |=> pump_out_oe == 2'h0 && filter_gate_pin_oe == 2'h0)
    else $error("Pump driven during leakage test");

  chk_tm3_switch:
  assert property (leak && tm3_open |=> fast_lock_switch == 2'h0)
    else $error("Switch still on after 16 pulses in test mode 3");

  chk_tm3_lock:
  assert property (leak ##1 leak |-> lock_indicator_oe == $past(tm3_cnt_ff >= 5'h10))
    else $error("Lock output wrong for pulse count in test mode 3");

  chk_lock_none_on:
  assert property (!leak && enabled == 2'h0 |=> !lock_indicator_oe)
    else $error("Lock output pulled low with no loop enabled");

  chk_vi_auto:
  assert property (opt_ff[9] && opt_ff[2:0] != 3'h7 && !loop_locked[0]
    |=> voltage_mode[0])
    else $error("Unlocked channel 1 not in voltage mode under auto");

  chk_vi_fixed:
  assert property (!opt_ff[9] && opt_ff[2:0] != 3'h7 |=> !voltage_mode[0])
    else $error("Channel 1 left current mode with auto off");

  chk_fl_disabled:
  assert property (restart_ff && !(opt_ff[9] && opt_ff[12]) ##1 !leak && !restart_ff
    |=> !fast_lock_switch[0])
    else $error("Fast-lock switch on while disabled");

  cov_option_load: cover property (opt_ser ##1 restart_ff);
  cov_tm3_done: cover property (leak && tm3_open);
  cov_fl_finish: cover property (fl_busy[0] ##1 !fl_busy[0] && !restart_ff);
  cov_lock_low: cover property (!leak ##1 lock_indicator_oe);
endmodule

//--- bench/serial_host.sv
// Host model driving the three-wire serial load pins
`timescale 1ns/1ps
module serial_host
(
  input wire logic pclk,
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  // Link clock stands high outside frames
  initial
  begin
    serial_clk = 1'b1;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Half period of 4 cycles gives the 800 ns link clock
  task automatic pulse();
    cyc(4);
    serial_clk <= 1'b0;
    cyc(4);
    serial_clk <= 1'b1;
  endtask
  task automatic send(input logic [18:0] w);
    for (int i = 18; i >= 0; i--)
    begin
      serial_data <= w[i];
      pulse();
    end
    // Released data shows the inverse, so a stale bit cannot pass
    serial_data <= ~w[0];
    cyc(4);
    load_strobe <= 1'b1;
    cyc(5);
    load_strobe <= 1'b0;
  endtask
  task automatic tmode(input logic s, input logic d, input int n);
    load_strobe <= s;
    serial_data <= d;
    repeat (n) pulse();
  endtask
endmodule

//--- bench/tb_dual_pll_option_control.sv
// Self-checking bench of the dual PLL option control block
`timescale 1ns/1ps
`define CHK(nm, x, y) begin n_checks++; if ((y) !== (x)) begin err_total++; \
  $display("mismatch %s exp %h got %h", nm, x, y); end end
module tb_dual_pll_option_control;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic sclk, sdata, strb, ten, rf1, rf2, mon, lk_o, lk_oe, pre1, pre2;
  logic [1:0] lead, lag, locked, pump, pump_oe, gate, gate_oe, fls, vmode, lwin, sres;
  logic [2:0] dc1, dc2;
  logic [16:0] r;
  logic [33:0] q[$];
  logic [33:0] e;
  // Entries are {expected lock pull, loop locked, prescalers on}
  logic [4:0] lkt [4] = '{5'h15, 5'h09, 5'h07, 5'h1f};
  int err_total, n_checks;
  dual_pll_option_control i_dual_pll_option_control (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clk(sclk),
    .serial_data(sdata), .load_strobe(strb), .test_enable(ten), .rf_input_ch1(rf1),
    .rf_input_ch2(rf2), .phase_lead(lead), .phase_lag(lag), .loop_locked(locked),
    .pump_out(pump), .pump_out_oe(pump_oe), .filter_gate_pin(gate),
    .filter_gate_pin_oe(gate_oe), .fast_lock_switch(fls), .voltage_mode(vmode),
    .drive_code1(dc1), .drive_code2(dc2), .prescaler1_on(pre1), .prescaler2_on(pre2),
    .lock_window_sel(lwin), .switch_res_sel(sres), .lock_indicator_o(lk_o),
    .lock_indicator_oe(lk_oe), .monitor_out(mon));
  serial_host i_serial_host (.pclk(pclk), .serial_clk(sclk), .serial_data(sdata),
    .load_strobe(strb));
  always #50 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // For reads d is the expected data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
    int k;
    k = 0;
    q.push_back({w, er, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      print_verdict();
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      e = q.pop_front();
      `CHK("pslverr", e[32], pslverr)
      if (!e[33])
        `CHK("prdata", e[31:0], prdata)
    end
  task automatic rf_run(input logic ch);
    int n;
    n = 0;
    repeat (65)
    begin
      rf1 <= !ch;
      rf2 <= ch;
      cyc(3);
      rf1 <= 1'b0;
      rf2 <= 1'b0;
      cyc(3);
      n += int'(mon === 1'b1);
    end
    `CHK("monitor", 7'h21, n[6:0])
  endtask
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ten = 0; rf1 = 0; rf2 = 0; lead = 0; lag = 0; locked = 0;
    err_total = 0; n_checks = 0; rnd = 32'h474b1c0b;
    cyc(4);
    presetn <= 1'b1;
    apb(0, pll_opt_pkg::OFS_OPTION, 32'h0, 0);
    apb(0, pll_opt_pkg::OFS_STATUS, 32'h0, 0);
    apb(1, 8'h0c, 32'h1, 1);
    apb(0, 8'h0c, 32'h0, 1);
    apb(1, pll_opt_pkg::OFS_WORD, 32'h5a5a5, 0);
    apb(0, pll_opt_pkg::OFS_WORD, 32'h0, 0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      r = rnd[16:0];
      r[11:10] = i[1:0];
      r[15] = i[1];
      r[16] = i[0];
      i_serial_host.send({2'b01, r});
      cyc(10);
      `CHK("drive1", r[2:0], dc1)
      `CHK("drive2", r[5:3], dc2)
      `CHK("pre1", r[7], pre1)
      `CHK("pre2", r[8], pre2)
      `CHK("window", r[11:10], lwin)
      `CHK("switch res", {r[15], r[16]}, sres)
      apb(0, pll_opt_pkg::OFS_OPTION, {15'h0, r}, 0);
      i_serial_host.send({2'b00, ~r});
      cyc(10);
      `CHK("kept", r[5:0], {dc2, dc1})
      apb(0, pll_opt_pkg::OFS_WORD, {15'h0, ~r}, 0);
    end
    for (int p = 0; p < 2; p++)
    begin
      apb(1, pll_opt_pkg::OFS_OPTION, {25'h0, p[0], 6'h0}, 0);
      lead <= 2'h3;
      cyc(3);
      `CHK("pump lead", {2{p[0]}}, pump)
      `CHK("pump oe", 2'h3, pump_oe)
      `CHK("current", 2'h0, vmode)
      lead <= 2'h0;
      lag <= 2'h3;
      cyc(3);
      `CHK("pump lag", {2{~p[0]}}, pump)
      lag <= 2'h0;
      cyc(3);
      `CHK("pump sync", 2'h0, pump_oe)
    end
    apb(1, pll_opt_pkg::OFS_OPTION, 32'h200, 0);
    lead <= 2'h3;
    cyc(3);
    `CHK("voltage", 2'h3, vmode)
    locked <= 2'h3;
    cyc(3);
    `CHK("current", 2'h0, vmode)
    apb(1, pll_opt_pkg::OFS_OPTION, 32'h3f, 0);
    cyc(3);
    `CHK("voltage 111", 2'h3, vmode)
    // Reversal field 00 first, as a host picking the resistance would
    for (int c = 0; c < 4; c++)
    begin
      locked <= 2'h0;
      // Start every run from a lead, so each step below is one reversal
      lead <= 2'h3;
      lag <= 2'h0;
      apb(1, pll_opt_pkg::OFS_OPTION, {17'h0, c[0], c[1], 13'h1200}, 0);
      cyc(4);
      `CHK("gate route", 2'h3, gate_oe)
      `CHK("switch on", 2'h3, fls)
      for (int j = 1; j <= (1 << c); j++)
      begin
        `CHK("still gate", 2'h3, gate_oe)
        `CHK("gate level", j[0] ? 2'h0 : 2'h3, gate)
        lead <= j[0] ? 2'h0 : 2'h3;
        lag <= j[0] ? 2'h3 : 2'h0;
        cyc(4);
      end
      `CHK("pump route", 2'h3, pump_oe)
      `CHK("gate off", 2'h0, gate_oe)
      `CHK("switch off", 2'h0, fls)
    end
    apb(1, pll_opt_pkg::OFS_OPTION, 32'h1000, 0);
    cyc(4);
    `CHK("no gate", 2'h0, gate_oe)
    lag <= 2'h0;
    lead <= 2'h3;
    for (int k = 0; k < 4; k++)
    begin
      apb(1, pll_opt_pkg::OFS_OPTION, {23'h0, lkt[k][1:0], 7'h0}, 0);
      locked <= lkt[k][3:2];
      cyc(4);
      `CHK("lock pull", lkt[k][4], lk_oe)
      apb(0, pll_opt_pkg::OFS_STATUS, {24'h0, lkt[k][4], 2'h0, lkt[k][3:2], 3'h1}, 0);
    end
    `CHK("lock pin", 1'b0, lk_o)
    ten <= 1'b1;
    i_serial_host.tmode(1'b1, 1'b0, 0);
    cyc(6);
    rf_run(1'b0);
    i_serial_host.tmode(1'b0, 1'b1, 0);
    cyc(6);
    rf_run(1'b1);
    i_serial_host.tmode(1'b1, 1'b1, 15);
    cyc(8);
    `CHK("leak", 2'h0, pump_oe)
    `CHK("switch 15", 2'h3, fls)
    `CHK("lock 15", 1'b0, lk_oe)
    i_serial_host.tmode(1'b1, 1'b1, 1);
    // Count, then lock and switch flops, settle about six cycles after the edge
    cyc(8);
    `CHK("switch 16", 2'h0, fls)
    `CHK("lock 16", 1'b1, lk_oe)
    print_verdict();
  end
endmodule
